// file: osdca_consts.svh
// Constants of the character attribute logic: register map, field
// positions, reset values, timing counts and special character codes.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef OSDCA_CONSTS_SVH
`define OSDCA_CONSTS_SVH

// ****************************************************************
// Register map (byte addresses on the AHB-Lite port)
// ****************************************************************
`define OSDCA_ADDR_CTRL 8'h00
`define OSDCA_ADDR_STATUS 8'h04
`define OSDCA_CTRL_RST 8'h00

// ****************************************************************
// Control register fields
// ****************************************************************
`define OSDCA_C_PREDIV2 0
`define OSDCA_C_DOT15 1
`define OSDCA_C_SHADOW 2
`define OSDCA_C_FSCOPE 3
`define OSDCA_C_SOLID_EN 4
`define OSDCA_C_SOLID_B 5
`define OSDCA_C_FLONG 6

// ****************************************************************
// Flash timing in vertical sync periods
// ****************************************************************
`define OSDCA_FLASH_ON_SHORT 6'd24
`define OSDCA_FLASH_ON_LONG 6'd48
`define OSDCA_FLASH_OFF 6'd8

// ****************************************************************
// Cell geometry, italic slant and border width
// ****************************************************************
`define OSDCA_UL_LINE_A 5'd23
`define OSDCA_UL_LINE_B 5'd24
`define OSDCA_FONT_LINES 5'd20
`define OSDCA_IT_STEPS_R1 5'd5
`define OSDCA_IT_STEPS_R2 5'd10
`define OSDCA_IT_DEPTH 10
`define OSDCA_BORDER_HALF 2'd2
`define OSDCA_BORDER_HALF15 2'd3
`define OSDCA_COL_NARROW 4'd12

// ****************************************************************
// Character codes, palette entries and cell widths
// ****************************************************************
`define OSDCA_CODE_BLANK 10'h009
`define OSDCA_CODE_N12_LO 10'h0f0
`define OSDCA_CODE_N12_HI 10'h0fd
`define OSDCA_CODE_STOP8 10'h3fe
`define OSDCA_CODE_STOP4 10'h3ff
`define OSDCA_PAL_BLACK 4'h8
`define OSDCA_PAL_NONE 4'h0
`define OSDCA_W16 5'h10
`define OSDCA_W12 5'h0c
`define OSDCA_W8 5'h08
`define OSDCA_W4 5'h04

`endif

// file: osdca_pkg.sv
// Types shared by the character attribute logic modules.
// Assumes nothing of its surroundings.
package osdca_pkg;

   // Display mode of the block the current character belongs to.
   typedef enum logic [1:0] {
      OSDCA_MODE_CC = 2'b00,
      OSDCA_MODE_STD = 2'b01,
      OSDCA_MODE_PART = 2'b10,
      OSDCA_MODE_OTHER = 2'b11
   } osdca_mode_t;

   // Phase of the flash cycle.
   typedef enum logic {
      OSDCA_FL_SHOW = 1'b0,
      OSDCA_FL_HIDE = 1'b1
   } osdca_phase_t;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic sync3;
      osdca_phase_t phase;
      logic [5:0] cnt;
   } osdca_flash_st_t;

   typedef struct packed {
      logic [9:0] sr;
   } osdca_ital_st_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic wr_pend;
      logic [7:0] addr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic stopped;
      logic past_last;
      logic [1:0] bcnt;
      logic prev_font;
      logic [3:0] rgb;
      logic out_a;
      logic out_b;
      logic [4:0] width;
   } osdca_top_st_t;

endpackage

// file: osdca_flash_timer.sv
// Flash phase timer counting vertical sync periods.
// Assumes vsync comes from a pin, asynchronous to sys_clk.
`timescale 1ns/100ps
`include "osdca_consts.svh"

module osdca_flash_timer (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic vsync_pin,
   input wire logic long_period,
   output logic visible,
   output logic [5:0] count
);

   osdca_pkg::osdca_flash_st_t st;
   osdca_pkg::osdca_flash_st_t next_st;
   logic vs_edge;
   logic [5:0] on_len;

   // Counts sync edges; the visible phase ends after 24 or 48 edges and
   // the blanked phase after 8.
   always_comb begin
      next_st = st;
      next_st.sync1 = vsync_pin;
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      vs_edge = st.sync2 & ~st.sync3;
      on_len = long_period ? `OSDCA_FLASH_ON_LONG : `OSDCA_FLASH_ON_SHORT;
      if (vs_edge) begin
         next_st.cnt = st.cnt + 6'd1;
         if (st.phase == osdca_pkg::OSDCA_FL_SHOW) begin
            if (st.cnt + 6'd1 >= on_len) begin // R5
               next_st.phase = osdca_pkg::OSDCA_FL_HIDE;
               next_st.cnt = 6'd0;
            end
         end else if (st.cnt + 6'd1 >= `OSDCA_FLASH_OFF) begin // R5
            next_st.phase = osdca_pkg::OSDCA_FL_SHOW;
            next_st.cnt = 6'd0;
         end
      end
   end

   // Registers the timer state.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign visible = (st.phase == osdca_pkg::OSDCA_FL_SHOW);
   assign count = st.cnt;

   // Blanked phase ends on the eighth sync edge.
   hide_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
      vs_edge && st.phase == osdca_pkg::OSDCA_FL_HIDE && st.cnt == 6'd7
      |=> st.phase == osdca_pkg::OSDCA_FL_SHOW)
      else $error("blanked flash phase not eight periods");
   phase_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
      !vs_edge |=> $stable(st.phase) && $stable(st.cnt))
      else $error("flash phase moved without a sync edge");
   show_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
      vs_edge && !long_period && st.cnt == 6'd23 &&
      st.phase == osdca_pkg::OSDCA_FL_SHOW
      |=> st.phase == osdca_pkg::OSDCA_FL_HIDE)
      else $error("short visible phase not 24 periods");
   flash_hide_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(st.phase == osdca_pkg::OSDCA_FL_HIDE));

endmodule

// file: osdca_italic_slant.sv
// Slants the font dot stream to the right for italic rendering.
// Assumes dot_tick marks each half predivided dot period, same clock.
`timescale 1ns/100ps
`include "osdca_consts.svh"

module osdca_italic_slant #(
   parameter int DEPTH = `OSDCA_IT_DEPTH
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic dot_tick,
   input wire logic font_dot,
   input wire logic italic_on,
   input wire logic prediv2,
   input wire logic [4:0] line_num,
   output logic font_out
);

   osdca_pkg::osdca_ital_st_t st;
   osdca_pkg::osdca_ital_st_t next_st;
   logic [3:0] shift;

   // Shift in half dots: top line most, bottom line none.
   function automatic logic [3:0] shift_of(input logic [4:0] line,
                                           input logic r2);
      logic [4:0] l0;
      logic [4:0] s;
      l0 = line - 5'd1;
      s = 5'd0;
      if (line != 5'd0 && line <= `OSDCA_FONT_LINES) begin
         if (r2) begin
            s = `OSDCA_IT_STEPS_R2 - 5'd1 - (l0 >> 1); // R7
         end else begin
            s = (`OSDCA_IT_STEPS_R1 - 5'd1 - (l0 >> 2)) << 1; // R7
         end
      end
      return s[3:0];
   endfunction

   // Keeps the recent dot history and taps it at the slant distance.
   always_comb begin
      next_st = st;
      shift = shift_of(line_num, prediv2);
      if (dot_tick) begin
         next_st.sr = {st.sr[DEPTH-2:0], font_dot};
      end
      if (italic_on && shift != 4'd0) begin
         font_out = st.sr[shift - 4'd1]; // R6
      end else begin
         font_out = font_dot;
      end
   end

   // Registers the history.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   plain_font_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !italic_on |-> font_out == font_dot) // R6
      else $error("font moved without italic");

endmodule

// file: osdca_attr_top.sv
// Character attribute and luminance control logic of the display.
// Assumes a same-clock character pipeline feeds the cell inputs, vsync
// comes from a pin, and software owns the AHB-Lite register port.
//
// How it works
// R1 - CC underline on cell lines 23 and 24
// R2 - Underline takes the font colour
// R3 - CC flash per character: font, underline, background
// R4 - Flash scope bit picks font-only or whole area
// R5 - Flash shows 24 or 48 syncs, hides 8
// R6 - CC italic slants the font rightward
// R7 - Slant: 1 dot x5 or half dot x10
// R8 - Software keeps dot clock 11-14 MHz
// R9 - Italic flashes as italic; output b never flashes
// R10 - Slant moves font edge, neighbours slant too
// R11 - Italic last character clipped when solid off
// R12 - Standard/particular borders, all-round or shadow
// R13 - Border on output a, black, per block
// R14 - Border one dot wide, 1.5 exception
// R15 - Font beats border; border beats background
// R16 - Solid space enable and output select bits
// R17 - Solid space: non-blank cells and row sides
// R18 - Output-a solid space forces black background
// R19 - Luminance outputs follow solid space settings
// R20 - Particular mode widths 16, 12, 8, 4
// R21 - Codes f0-fd show left 12 dots
// R22 - Stop codes blank rest of row
`timescale 1ns/100ps
`include "osdca_consts.svh"

module osdca_attr_top (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic vsync_pin,
   input wire logic dot_tick,
   input wire logic row_start,
   input wire osdca_pkg::osdca_mode_t block_mode,
   input wire logic block_border_on,
   input wire logic in_char_area,
   input wire logic side_area,
   input wire logic last_char,
   input wire logic [9:0] char_code,
   input wire logic [3:0] dot_col,
   input wire logic [4:0] line_num,
   input wire logic font_dot,
   input wire logic font_above,
   input wire logic font_below,
   input wire logic font_ahead,
   input wire logic italic_attr_bit,
   input wire logic nbr_italic,
   input wire logic flash_attr_bit,
   input wire logic underline_attr_bit,
   input wire logic char_out_select_bit,
   input wire logic [3:0] fg_palette,
   input wire logic [3:0] bg_palette,
   output logic [3:0] rgb_palette,
   output logic luminance_ctrl_out_a,
   output logic luminance_ctrl_out_b,
   output logic [4:0] cell_width
);

   osdca_pkg::osdca_top_st_t st;
   osdca_pkg::osdca_top_st_t next_st;
   logic flash_vis;
   logic [5:0] flash_cnt;
   logic font_sl;
   logic cc, bordered, part, italic_on, solid_on, solid_a;
   logic solid_area, stop_hit, n12, font_vis, ul, flash_off;
   logic fg_on, border_hit, border_on, addr_ph;
   logic [3:0] bgp;
   logic [1:0] bwidth;

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Read word: control byte, or status with flash phase, its count, and the row stop flag.
   function automatic logic [31:0] read_word(input logic [7:0] a,
                                             input logic [7:0] c,
                                             input logic v,
                                             input logic [5:0] n,
                                             input logic s);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (a == `OSDCA_ADDR_CTRL) begin
         w = {24'h00_0000, c};
      end else if (a == `OSDCA_ADDR_STATUS) begin
         w = {24'h00_0000, s, n, v};
      end
      return w;
   endfunction

   // Cell width in dots chosen by the character code.
   function automatic logic [4:0] width_of(input logic p,
                                           input logic [9:0] code);
      logic [4:0] w;
      w = `OSDCA_W16;
      if (p) begin
         if (code >= `OSDCA_CODE_N12_LO && code <= `OSDCA_CODE_N12_HI) begin
            w = `OSDCA_W12;
         end else if (code == `OSDCA_CODE_STOP8) begin
            w = `OSDCA_W8;
         end else if (code == `OSDCA_CODE_STOP4) begin
            w = `OSDCA_W4;
         end
      end
      return w;
   endfunction

   // ****************************************************************
   // Submodules
   // ****************************************************************

   osdca_flash_timer u_flash (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .vsync_pin(vsync_pin),
      .long_period(st.ctrl[`OSDCA_C_FLONG]),
      .visible(flash_vis),
      .count(flash_cnt)
   );

   osdca_italic_slant #(
      .DEPTH(`OSDCA_IT_DEPTH)
   ) u_italic (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .dot_tick(dot_tick),
      .font_dot(font_dot),
      .italic_on(italic_on),
      .prediv2(st.ctrl[`OSDCA_C_PREDIV2]),
      .line_num(line_num),
      .font_out(font_sl)
   );

   // ****************************************************************
   // Next state: bus slave, row tracking and dot composition
   // ****************************************************************

   always_comb begin
      next_st = st;
      // Bus: zero wait state, always OKAY, read data set up in the
      // address phase so it stands in the data phase.
      addr_ph = hsel & htrans[1] & hready;
      next_st.hreadyout = 1'b1;
      if (st.wr_pend && st.addr == `OSDCA_ADDR_CTRL) begin
         next_st.ctrl = hwdata[7:0];
      end
      next_st.wr_pend = addr_ph & hwrite;
      if (addr_ph) begin
         next_st.addr = haddr;
      end
      if (addr_ph && !hwrite) begin
         next_st.hrdata = read_word(haddr, st.ctrl, flash_vis, flash_cnt,
                                    st.stopped);
      end

      // Mode decode.
      cc = (block_mode == osdca_pkg::OSDCA_MODE_CC);
      part = (block_mode == osdca_pkg::OSDCA_MODE_PART);
      bordered = (block_mode == osdca_pkg::OSDCA_MODE_STD) | part; // R12
      italic_on = cc & (italic_attr_bit | nbr_italic); // R6 R10
      solid_on = cc & st.ctrl[`OSDCA_C_SOLID_EN]; // R16
      solid_a = solid_on & ~st.ctrl[`OSDCA_C_SOLID_B]; // R16
      solid_area = solid_on & ((in_char_area &
         (char_code != `OSDCA_CODE_BLANK)) | side_area); // R17

      // Stop codes end the row in particular blocks; a stop seen in the
      // same cycle as row_start still wins.
      stop_hit = part & in_char_area &
         (char_code == `OSDCA_CODE_STOP8 ||
          char_code == `OSDCA_CODE_STOP4); // R22
      if (row_start) begin
         next_st.stopped = 1'b0;
         next_st.past_last = 1'b0;
      end
      if (stop_hit) begin
         next_st.stopped = 1'b1; // R22
      end
      if (last_char && italic_attr_bit && cc) begin
         next_st.past_last = 1'b1; // R11
      end

      // Font after width mask, slant and last-cell clipping.
      n12 = part & (char_code >= `OSDCA_CODE_N12_LO) &
         (char_code <= `OSDCA_CODE_N12_HI) &
         (dot_col >= `OSDCA_COL_NARROW); // R21
      font_vis = font_sl & ~n12 & ~stop_hit & ~st.stopped &
         ~(st.past_last & ~in_char_area & ~solid_on); // R10 R11 R20
      ul = cc & underline_attr_bit & in_char_area &
         (line_num == `OSDCA_UL_LINE_A ||
          line_num == `OSDCA_UL_LINE_B); // R1
      flash_off = cc & flash_attr_bit & ~flash_vis; // R3 R9
      fg_on = (font_vis | ul) & ~flash_off; // R4

      // Border: bottom and right always, top and left when all-round.
      // The right edge is stretched over whole half-dot ticks.
      bwidth = (st.ctrl[`OSDCA_C_PREDIV2] & st.ctrl[`OSDCA_C_DOT15]) ?
         `OSDCA_BORDER_HALF15 : `OSDCA_BORDER_HALF; // R14
      if (dot_tick) begin
         next_st.prev_font = font_dot;
         if (st.prev_font && !font_dot) begin
            next_st.bcnt = bwidth; // R14
         end else if (st.bcnt != 2'd0) begin
            next_st.bcnt = st.bcnt - 2'd1;
         end
      end
      border_hit = font_above | (st.bcnt != 2'd0) |
         (~st.ctrl[`OSDCA_C_SHADOW] & (font_below | font_ahead)); // R12
      border_on = bordered & block_border_on & in_char_area & border_hit &
         ~font_vis & ~st.stopped & ~stop_hit; // R13 R15

      // Background colour; black when output a carries solid space.
      bgp = (solid_a & solid_area) ? `OSDCA_PAL_BLACK : bg_palette; // R18

      // Colour priority: font, then border, then background.
      if (fg_on) begin
         next_st.rgb = fg_palette; // R2
      end else if (border_on) begin
         next_st.rgb = `OSDCA_PAL_BLACK; // R13 R15
      end else if (in_char_area) begin
         next_st.rgb = bgp;
      end else begin
         next_st.rgb = `OSDCA_PAL_NONE;
      end

      // Luminance outputs.
      next_st.out_a = solid_a ? solid_area : (in_char_area | border_on);
      next_st.out_b = (solid_on & st.ctrl[`OSDCA_C_SOLID_B] & solid_area) |
         (char_out_select_bit & in_char_area); // R19

      // Whole-area flash; output b is left alone.
      if (flash_off && st.ctrl[`OSDCA_C_FSCOPE] && in_char_area) begin
         next_st.rgb = `OSDCA_PAL_NONE; // R4
         if (!solid_area) begin
            next_st.out_a = 1'b0; // R4 R9
         end
      end

      // After a stop code nothing further is drawn on the row.
      if (st.stopped) begin
         next_st.rgb = `OSDCA_PAL_NONE; // R22
         next_st.out_a = 1'b0;
         next_st.out_b = 1'b0;
      end
      next_st.width = width_of(part, char_code); // R20
   end

   // ****************************************************************
   // State register and outputs
   // ****************************************************************

   // Registers all state.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st <= '0;
         st.ctrl <= `OSDCA_CTRL_RST;
         st.hreadyout <= 1'b1;
         st.width <= `OSDCA_W16;
      end else begin
         st <= next_st;
      end
   end

   assign hrdata = st.hrdata;
   assign hreadyout = st.hreadyout;
   assign hresp = 1'b0;
   assign rgb_palette = st.rgb;
   assign luminance_ctrl_out_a = st.out_a;
   assign luminance_ctrl_out_b = st.out_b;
   assign cell_width = st.width;

   // ****************************************************************
   // Checks
   // ****************************************************************

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   underline_colour_a: assert property ( // R2
      ul && !flash_off && !st.stopped && !stop_hit
      |=> rgb_palette == $past(fg_palette))
      else $error("underline not drawn in font colour");
   border_black_a: assert property ( // R13
      border_on && !fg_on |=> rgb_palette == `OSDCA_PAL_BLACK)
      else $error("border not black");
   font_over_border_a: assert property ( // R15
      !cc && font_vis && !st.stopped |=> rgb_palette == $past(fg_palette))
      else $error("border hid the font");
   flash_area_a: assert property ( // R4
      flash_off && st.ctrl[`OSDCA_C_FSCOPE] && in_char_area &&
      !solid_area && !st.stopped
      |=> !luminance_ctrl_out_a && rgb_palette == `OSDCA_PAL_NONE)
      else $error("whole-area flash left output a or colour on");
   b_noflash_a: assert property ( // R9
      char_out_select_bit && in_char_area && !st.stopped
      |=> luminance_ctrl_out_b)
      else $error("output b dropped in character area");
   solid_black_a: assert property ( // R18
      solid_a && solid_area && in_char_area && !fg_on && !border_on &&
      !flash_off && !st.stopped
      |=> rgb_palette == `OSDCA_PAL_BLACK && luminance_ctrl_out_a)
      else $error("solid background not black on output a");
   stop_hold_a: assert property ( // R22
      stop_hit ##1 !row_start |=> st.stopped && rgb_palette == 4'h0 &&
      !luminance_ctrl_out_a && !luminance_ctrl_out_b)
      else $error("row not blanked after stop code");
   narrow_mask_a: assert property ( // R21
      n12 |-> !font_vis)
      else $error("dots beyond twelve shown");
   bus_ready_a: assert property (
      hsel && htrans[1] |=> hreadyout && !hresp)
      else $error("bus slave not ready with OKAY");

   solid_c: cover property (solid_on && solid_area ##1 luminance_ctrl_out_a);
   border_c: cover property (border_on);
   stop_c: cover property (stop_hit ##1 st.stopped);
   italic_c: cover property (italic_on && font_sl != font_dot);

endmodule

// file: osdca_crt_model.sv
// Far side of the display path: makes vertical sync pulses on demand.
// Assumes the bench raises run and watches frames to count pulses.
`timescale 1ns/100ps
module osdca_crt_model #(
   parameter int PERIOD = 16
) (
   input wire logic sys_clk,
   input wire logic run,
   output logic vsync_pin = 1'h0,
   output int frames = 0
);
   int ph = 0;
   // One pulse a quarter period high per frame; a frame in flight ends.
   always @(posedge sys_clk) begin
      if (run || ph != 0) begin
         ph <= (ph + 1) % PERIOD;
         vsync_pin <= (ph < PERIOD / 4);
         if (ph == 0) begin
            frames <= frames + 1;
         end
      end
   end
endmodule

// file: tb.sv
// Self-checking bench: register access over the bus, then cell stimulus.
// Assumes the attribute top, its package and the sync model compile first.
`timescale 1ns/100ps
`include "osdca_consts.svh"
module tb;
   logic sys_clk = 1'h0, sys_rst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, hrdata, rd;
   logic hreadyout, hresp, vsync_pin, run = 1'h0, dot_tick = 1'h0;
   logic row_start = 1'h0, block_border_on = 1'h0, in_char_area = 1'h0;
   logic side_area = 1'h0, last_char = 1'h0, font_dot = 1'h0;
   logic font_above = 1'h0, font_below = 1'h0, font_ahead = 1'h0;
   logic italic_attr_bit = 1'h0, nbr_italic = 1'h0, flash_attr_bit = 1'h0;
   logic underline_attr_bit = 1'h0, char_out_select_bit = 1'h0;
   logic luminance_ctrl_out_a, luminance_ctrl_out_b;
   logic [3:0] fg_palette = 4'h5, bg_palette = 4'h3, rgb_palette;
   logic [3:0] dot_col = 4'h0;
   logic [9:0] char_code = 10'h041;
   logic [4:0] line_num = 5'h01, cell_width;
   osdca_pkg::osdca_mode_t block_mode = osdca_pkg::OSDCA_MODE_CC;
   logic [9:0] codes [5] = '{10'h0f0, 10'h0fd, 10'h0fe, 10'h0f0, 10'h3ff};
   logic [4:0] widths [5] = '{5'h0c, 5'h0c, 5'h10, 5'h10, 5'h04};
   int n_fail = 0, checks_done = 0, frames;
   // ********************
   // Clock, dot tick and instances
   // ********************
   always #2 sys_clk = ~sys_clk;
   // Dot ticks every second cycle; no italic runs at ratio 1, so the dot
   // clock limit for it never binds the bench.
   always @(posedge sys_clk) dot_tick <= ~dot_tick;
   osdca_attr_top uut (.sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
      .vsync_pin, .dot_tick, .row_start, .block_mode, .block_border_on,
      .in_char_area, .side_area, .last_char, .char_code, .dot_col,
      .line_num, .font_dot, .font_above, .font_below, .font_ahead,
      .italic_attr_bit, .nbr_italic, .flash_attr_bit, .underline_attr_bit,
      .char_out_select_bit, .fg_palette, .bg_palette, .rgb_palette,
      .luminance_ctrl_out_a, .luminance_ctrl_out_b, .cell_width);
   osdca_crt_model crt (.sys_clk, .run, .vsync_pin, .frames);
   // ********************
   // Tasks
   // ********************
   task automatic cmp(string what, logic [31:0] got, logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Waits for an edge where the slave is ready, with a bound.
   task automatic rdy();
      int k = 0;
      @(posedge sys_clk);
      while (hreadyout !== 1'h1) begin
         k++;
         if (k > 64) begin
            n_fail++;
            summarize();
         end
         @(posedge sys_clk);
      end
   endtask
   // One single word transfer; read data lands in rd.
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      rdy();
      htrans <= 2'h0;
      hsel <= 1'h0;
      hwdata <= d;
      rdy();
      rd = hrdata;
   endtask
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic vchk(logic [3:0] c, logic a, logic b);
      tick();
      cmp("rgb", {28'h0, rgb_palette}, {28'h0, c});
      cmp("out_a", {31'h0, luminance_ctrl_out_a}, {31'h0, a});
      cmp("out_b", {31'h0, luminance_ctrl_out_b}, {31'h0, b});
      @(posedge sys_clk);
   endtask
   // Sends n sync pulses, then checks the visible flag of the flash.
   task automatic fl(int n, logic v);
      int k = 0, goal;
      goal = frames + n;
      @(posedge sys_clk);
      run <= 1'h1;
      while (frames < goal) begin
         k++;
         if (k > 5000) begin
            n_fail++;
            summarize();
         end
         @(posedge sys_clk);
      end
      run <= 1'h0;
      repeat (24) @(posedge sys_clk);
      bus(1'h0, `OSDCA_ADDR_STATUS, 32'h0);
      cmp("visible", {31'h0, rd[0]}, {31'h0, v});
   endtask
   // ********************
   // Main sequence
   // ********************
   initial begin
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'h0;
      bus(1'h0, `OSDCA_ADDR_CTRL, 32'h0);
      cmp("ctrl", rd, 32'h0);
      bus(1'h0, `OSDCA_ADDR_STATUS, 32'h0);
      cmp("status", rd, 32'h1);
      bus(1'h1, 8'h08, 32'hff);
      bus(1'h0, 8'h08, 32'h0);
      cmp("unmapped", rd, 32'h0);
      bus(1'h1, `OSDCA_ADDR_CTRL, 32'h7f);
      bus(1'h0, `OSDCA_ADDR_CTRL, 32'h0);
      cmp("ctrl", rd, 32'h7f);
      cmp("hresp", {31'h0, hresp}, 32'h0);
      $display("test registers done");
      bus(1'h1, `OSDCA_ADDR_CTRL, 32'h0);
      in_char_area <= 1'h1;
      font_dot <= 1'h1;
      char_out_select_bit <= 1'h1;
      vchk(4'h5, 1'h1, 1'h1);
      font_dot <= 1'h0;
      vchk(4'h3, 1'h1, 1'h1);
      line_num <= 5'h17;
      underline_attr_bit <= 1'h1;
      char_out_select_bit <= 1'h0;
      vchk(4'h5, 1'h1, 1'h0);
      line_num <= 5'h18;
      vchk(4'h5, 1'h1, 1'h0);
      line_num <= 5'h16;
      vchk(4'h3, 1'h1, 1'h0);
      $display("test underline done");
      line_num <= 5'h05;
      underline_attr_bit <= 1'h0;
      bus(1'h1, `OSDCA_ADDR_CTRL, 32'h10);
      vchk(4'h8, 1'h1, 1'h0);
      char_code <= `OSDCA_CODE_BLANK;
      vchk(4'h3, 1'h0, 1'h0);
      side_area <= 1'h1;
      in_char_area <= 1'h0;
      vchk(4'h0, 1'h1, 1'h0);
      side_area <= 1'h0;
      in_char_area <= 1'h1;
      char_code <= 10'h041;
      bus(1'h1, `OSDCA_ADDR_CTRL, 32'h30);
      vchk(4'h3, 1'h1, 1'h1);
      $display("test solid space done");
      bus(1'h1, `OSDCA_ADDR_CTRL, 32'h0);
      block_mode <= osdca_pkg::OSDCA_MODE_STD;
      block_border_on <= 1'h1;
      for (int i = 0; i < 3; i++) begin
         {font_above, font_below, font_ahead} <= 3'h4 >> i;
         vchk(4'h8, 1'h1, 1'h0);
      end
      bus(1'h1, `OSDCA_ADDR_CTRL, 32'h04);
      {font_above, font_below, font_ahead} <= 3'h2;
      vchk(4'h3, 1'h1, 1'h0);
      font_dot <= 1'h1;
      font_above <= 1'h1;
      vchk(4'h5, 1'h1, 1'h0);
      font_dot <= 1'h0;
      block_border_on <= 1'h0;
      vchk(4'h3, 1'h1, 1'h0);
      $display("test border done");
      for (int i = 0; i < 5; i++) begin
         block_mode <= (i == 3) ? osdca_pkg::OSDCA_MODE_STD
            : osdca_pkg::OSDCA_MODE_PART;
         char_code <= codes[i];
         tick();
         cmp("width", {27'h0, cell_width}, {27'h0, widths[i]});
         @(posedge sys_clk);
      end
      char_code <= 10'h041;
      font_dot <= 1'h1;
      vchk(4'h0, 1'h0, 1'h0);
      @(posedge sys_clk);
      row_start <= 1'h1;
      @(posedge sys_clk);
      row_start <= 1'h0;
      vchk(4'h5, 1'h1, 1'h0);
      char_code <= `OSDCA_CODE_STOP8;
      tick();
      cmp("width", {27'h0, cell_width}, 32'h8);
      $display("test widths done");
      @(posedge sys_clk);
      row_start <= 1'h1;
      block_mode <= osdca_pkg::OSDCA_MODE_CC;
      block_border_on <= 1'h0;
      char_code <= 10'h041;
      flash_attr_bit <= 1'h1;
      char_out_select_bit <= 1'h1;
      bus(1'h1, `OSDCA_ADDR_CTRL, 32'h0);
      row_start <= 1'h0;
      fl(23, 1'h1);
      fl(1, 1'h0);
      vchk(4'h3, 1'h1, 1'h1);
      fl(7, 1'h0);
      fl(1, 1'h1);
      bus(1'h1, `OSDCA_ADDR_CTRL, 32'h40);
      fl(47, 1'h1);
      fl(1, 1'h0);
      $display("test flash done");
      summarize();
   end
endmodule
